// ### mfpg_top.sv
// multi-function port group: ports 2, 3 and 5 behind classic wishbone
// assumes one clock, synchronous reset, pins resolved by the bench
//
// Operation
// - port 2 has three pins; its latch bits reset to one
// - dual-clock mode gives pins 2.1, 2.2 to the sub oscillator
// - falling edge on pin 2.0 sets the external interrupt latch
// - port 2 latch reads back; separate read-only pin register
// - port 2 reads carry data only in bits 2 to 0
// - stop mode floats pin 2.0 regardless of output enable
// - port 3 bits 4,3: drive bit 0 open drain, 1 push-pull
// - reset sets port 3 latch ones except bits 6,5, drive control zero
// - port 3 latch reads back; pin register returns bits 4,3
// - port 3 bit 7 output only: 0 low, 1 high or divider
// - drive bits 2 and 1 enable serial clock and data outputs
// - unused port 3 register bits read as zero
// - port 5 has eight pins with own direction bits
// - port 5 latch, direction and lcd select reset to zero
// - lcd select one gives the pin to the lcd segment
// - port 5 read: pin, zero or latch by direction and select
// - port 5 direction 0 input, 1 output
`timescale 1ns/1ps
`include "mfpg_params.svh"
module mfpg_top import mfpg_pkg::*; #(
  parameter int ADDR_W = 14,
  parameter int P5_W = 8
) (
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // port 2 pins
  input wire logic [2:0] p2PadIn,
  output logic [2:0] p2PadOut,
  output logic [2:0] p2PadOeN,
  // port 3 pins, bits 4 and 3 two-way, bit 7 output only
  input wire logic [1:0] p3PadIn,
  output logic [1:0] p3PadOut,
  output logic [1:0] p3PadOeN,
  output logic p3DivPadOut,
  output logic p3DivPadOeN,
  // port 5 pins
  input wire logic [P5_W-1:0] p5PadIn,
  output logic [P5_W-1:0] p5PadOut,
  output logic [P5_W-1:0] p5PadOeN,
  // on-chip peripherals
  input wire logic dividerOutput,
  input wire logic [P5_W-1:0] lcdSegment,
  output logic subOscEnable,
  output logic externalIrqFiveSet,
  output logic serialClockOutEnable,
  output logic serialDataOutEnable
);
  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (ADDR_W < 14 || ADDR_W > 32) $error("mfpg_top: ADDR_W 14..32");
    if (P5_W != 8) $error("mfpg_top: P5_W must be 8");
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0] p2Latch_ff;
  logic [7:0] p3Latch_ff;
  logic [7:0] p3Drive_ff;
  logic [P5_W-1:0] p5Latch_ff;
  logic [P5_W-1:0] p5Dir_ff;
  logic [P5_W-1:0] p5Lcd_ff;
  logic [3:0] sysCtrl_ff;
  mfpg_bus_t busState_ff;
  logic [31:0] rdData_ff;
  logic p20Prev_ff;
  logic irqFall_ff;
  logic [31:0] nxt_rdData;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] p2Sync;
  logic [1:0] p3Sync;
  logic [P5_W-1:0] p5Sync;
  logic [P5_W-1:0] p5Read;

  mfpg_sync #(.WIDTH(3)) u_sync_p2 (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .asyncIn(p2PadIn),
    .syncOut(p2Sync)
  );

  mfpg_sync #(.WIDTH(2)) u_sync_p3 (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .asyncIn(p3PadIn),
    .syncOut(p3Sync)
  );

  mfpg_sync #(.WIDTH(P5_W)) u_sync_p5 (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .asyncIn(p5PadIn),
    .syncOut(p5Sync)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic isIdx(input logic [ADDR_W-1:0] adr,
                                 input logic [11:0] idx);
    isIdx = (adr[ADDR_W-1:2] == (ADDR_W-2)'(idx)) &&
            (adr[1:0] == 2'h0);
  endfunction

  logic busReq;
  logic wrLane;

  assign busReq = wb_cyc_i & wb_stb_i & (busState_ff == MFPG_IDLE);
  assign wrLane = busReq & wb_we_i & wb_sel_i[0];

  // ---------------------------------------------------------------
  // wishbone handshake, one wait state, ack for one cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      busState_ff <= MFPG_IDLE;
    end else if (ce) begin
      case (busState_ff)
        MFPG_IDLE: begin
          if (wb_cyc_i & wb_stb_i) begin
            busState_ff <= MFPG_ACK;
          end
        end
        MFPG_ACK: begin
          busState_ff <= MFPG_IDLE;
        end
        default: begin
          busState_ff <= MFPG_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_o = (busState_ff == MFPG_ACK) & wb_cyc_i & wb_stb_i;

  // ---------------------------------------------------------------
  // port 2 latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      p2Latch_ff <= `MFPG_RST_P2;
    end else if (ce && wrLane && isIdx(wb_adr_i, `MFPG_IDX_P2_LATCH)) begin
      p2Latch_ff <= wb_dat_i[2:0];
    end
  end

  // ---------------------------------------------------------------
  // port 3 latch and drive control
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      p3Latch_ff <= `MFPG_RST_P3;
    end else if (ce && wrLane && isIdx(wb_adr_i, `MFPG_IDX_P3_LATCH)) begin
      p3Latch_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      p3Drive_ff <= `MFPG_RST_DRV;
    end else if (ce && wrLane && isIdx(wb_adr_i, `MFPG_IDX_P3_DRIVE)) begin
      p3Drive_ff <= wb_dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // port 5 latch, direction and lcd select
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      p5Latch_ff <= `MFPG_RST_P5;
    end else if (ce && wrLane && isIdx(wb_adr_i, `MFPG_IDX_P5_LATCH)) begin
      p5Latch_ff <= wb_dat_i[P5_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      p5Dir_ff <= `MFPG_RST_P5;
    end else if (ce && wrLane && isIdx(wb_adr_i, `MFPG_IDX_P5_DIR)) begin
      p5Dir_ff <= wb_dat_i[P5_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      p5Lcd_ff <= `MFPG_RST_P5;
    end else if (ce && wrLane && isIdx(wb_adr_i, `MFPG_IDX_P5_LCD)) begin
      p5Lcd_ff <= wb_dat_i[P5_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // system control: dual clock, stop, output enable, divider select
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sysCtrl_ff <= `MFPG_RST_SYS;
    end else if (ce && wrLane && isIdx(wb_adr_i, `MFPG_IDX_SYS_CTRL)) begin
      sysCtrl_ff <= wb_dat_i[3:0];
    end
  end

  logic dualClk;
  logic stopMode;
  logic outGate;

  assign dualClk = sysCtrl_ff[`MFPG_SYS_DUAL];
  assign stopMode = sysCtrl_ff[`MFPG_SYS_STOP];
  // in stop, outputs stay driven only while output enable is set
  assign outGate = ~stopMode | sysCtrl_ff[`MFPG_SYS_GLOBAL_OUTPUT_ENABLE];

  // ---------------------------------------------------------------
  // read mux, undefined bits read as zero
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdData = 32'h0000_0000;
    if (isIdx(wb_adr_i, `MFPG_IDX_P2_LATCH)) begin
      nxt_rdData[2:0] = p2Latch_ff;
    end else if (isIdx(wb_adr_i, `MFPG_IDX_P2_PIN)) begin
      nxt_rdData[2:0] = p2Sync;
    end else if (isIdx(wb_adr_i, `MFPG_IDX_P3_LATCH)) begin
      nxt_rdData[7] = p3Latch_ff[7];
      nxt_rdData[4:3] = p3Latch_ff[4:3];
    end else if (isIdx(wb_adr_i, `MFPG_IDX_P3_DRIVE)) begin
      nxt_rdData[4:1] = p3Drive_ff[4:1];
    end else if (isIdx(wb_adr_i, `MFPG_IDX_P3_PIN)) begin
      nxt_rdData[4:3] = p3Sync;
    end else if (isIdx(wb_adr_i, `MFPG_IDX_P5_LATCH)) begin
      nxt_rdData[P5_W-1:0] = p5Read;
    end else if (isIdx(wb_adr_i, `MFPG_IDX_P5_DIR)) begin
      nxt_rdData[P5_W-1:0] = p5Dir_ff;
    end else if (isIdx(wb_adr_i, `MFPG_IDX_P5_LCD)) begin
      nxt_rdData[P5_W-1:0] = p5Lcd_ff;
    end else if (isIdx(wb_adr_i, `MFPG_IDX_SYS_CTRL)) begin
      nxt_rdData[3:0] = sysCtrl_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_ff <= 32'h0000_0000;
    end else if (ce && busReq) begin
      rdData_ff <= wb_we_i ? 32'h0000_0000 : nxt_rdData;
    end
  end

  assign wb_dat_o = rdData_ff;

  // ---------------------------------------------------------------
  // port 2 pins
  // ---------------------------------------------------------------
  // pin 2.0 floats in stop so it can wake the device
  assign p2PadOut[0] = p2Latch_ff[0];
  assign p2PadOeN[0] = ~(~stopMode & ~p2Latch_ff[0]);
  // pins 2.1, 2.2 belong to the sub oscillator in dual-clock mode
  assign p2PadOut[2:1] = p2Latch_ff[2:1];
  assign p2PadOeN[1] = dualClk | ~outGate | p2Latch_ff[1];
  assign p2PadOeN[2] = dualClk | ~outGate | p2Latch_ff[2];
  assign subOscEnable = dualClk;

  // ---------------------------------------------------------------
  // external interrupt edge from pin 2.0
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      p20Prev_ff <= 1'b0; // synchroniser resets low, so no false edge
      irqFall_ff <= 1'b0;
    end else if (ce) begin
      p20Prev_ff <= p2Sync[0];
      irqFall_ff <= p20Prev_ff & ~p2Sync[0];
    end
  end

  assign externalIrqFiveSet = irqFall_ff & ce;

  // ---------------------------------------------------------------
  // port 3 pins
  // ---------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_p3
      localparam int B = `MFPG_P3_OD_LO + k;
      // push-pull drives both levels, open drain only pulls low
      assign p3PadOut[k] = p3Latch_ff[B];
      assign p3PadOeN[k] = ~outGate |
        (~p3Drive_ff[B] & p3Latch_ff[B]);
    end
  endgenerate

  assign p3DivPadOut = p3Latch_ff[`MFPG_P3_DIV] &
    (sysCtrl_ff[`MFPG_SYS_DIVSEL] ? dividerOutput : 1'b1);
  assign p3DivPadOeN = ~outGate;

  assign serialClockOutEnable = p3Drive_ff[`MFPG_P3_SCK_EN];
  assign serialDataOutEnable = p3Drive_ff[`MFPG_P3_SDO_EN];

  // ---------------------------------------------------------------
  // port 5
  // ---------------------------------------------------------------
  mfpg_port5 #(.WIDTH(P5_W)) u_port5 (
    .latch(p5Latch_ff),
    .dir(p5Dir_ff),
    .lcdSel(p5Lcd_ff),
    .outGate(outGate),
    .lcdSeg(lcdSegment),
    .pinSync(p5Sync),
    .padOut(p5PadOut),
    .padOeN(p5PadOeN),
    .readVal(p5Read)
  );
endmodule

// ### mfpg_params.svh
// offsets, field positions, reset values and timing counts for the
// port group; included by the top, synchroniser and port 5 modules
`ifndef MFPG_PARAMS_SVH
`define MFPG_PARAMS_SVH
// register indices, byte address is four times the index
`define MFPG_IDX_P2_LATCH 12'h002
`define MFPG_IDX_P3_LATCH 12'h003
`define MFPG_IDX_P3_DRIVE 12'h004
`define MFPG_IDX_P5_LATCH 12'h005
`define MFPG_IDX_P5_DIR 12'h00a
`define MFPG_IDX_SYS_CTRL 12'h0f0
`define MFPG_IDX_P2_PIN 12'hf9c
`define MFPG_IDX_P3_PIN 12'hf9d
`define MFPG_IDX_P5_LCD 12'hf9f
// field positions
`define MFPG_P3_SDO_EN 1
`define MFPG_P3_SCK_EN 2
`define MFPG_P3_OD_LO 3
`define MFPG_P3_OD_HI 4
`define MFPG_P3_DIV 7
`define MFPG_SYS_DUAL 0
`define MFPG_SYS_STOP 1
`define MFPG_SYS_GLOBAL_OUTPUT_ENABLE 2
`define MFPG_SYS_DIVSEL 3
// reset values
`define MFPG_RST_P2 3'h7
`define MFPG_RST_P3 8'h9f
`define MFPG_RST_DRV 8'h00
`define MFPG_RST_P5 8'h00
`define MFPG_RST_SYS 4'h0
// timing: registered ack, one cycle after the request is seen
`define MFPG_ACK_CYCLES 1
`define MFPG_SYNC_STAGES 2
`endif

// ### mfpg_pkg.sv
// types shared by the port group modules
// assumes nothing beyond a SystemVerilog compiler
package mfpg_pkg;
  typedef enum logic [1:0] {
    MFPG_IDLE,
    MFPG_ACK
  } mfpg_bus_t;
  typedef logic [7:0] mfpg_byte_t;
endpackage

// ### mfpg_sync.sv
// two flip-flop synchroniser for a group of pin levels
// assumes clk is the block clock and ce freezes it
`timescale 1ns/1ps
`include "mfpg_params.svh"
module mfpg_sync import mfpg_pkg::*; #(
  parameter int WIDTH = 8
) (
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  initial begin
    if (WIDTH < 1) $error("mfpg_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else if (ce) begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule

// ### mfpg_port5.sv
// port 5 pin and read-back logic, one slice per pin
// assumes registers and synchronised pin levels come from the top
`timescale 1ns/1ps
`include "mfpg_params.svh"
module mfpg_port5 import mfpg_pkg::*; #(
  parameter int WIDTH = 8
) (
  // configuration
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] dir,
  input wire logic [WIDTH-1:0] lcdSel,
  input wire logic outGate,
  // lcd segment drive
  input wire logic [WIDTH-1:0] lcdSeg,
  // pin side
  input wire logic [WIDTH-1:0] pinSync,
  output logic [WIDTH-1:0] padOut,
  output logic [WIDTH-1:0] padOeN,
  // read-back
  output logic [WIDTH-1:0] readVal
);
  initial begin
    if (WIDTH < 1 || WIDTH > 8) $error("mfpg_port5: WIDTH 1..8");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      // lcd select overrides latch and direction at the pin; on read-back direction wins, and lcd select reads zero on inputs
      assign padOut[i] = lcdSel[i] ? lcdSeg[i] : latch[i];
      assign padOeN[i] = ~(outGate & (lcdSel[i] | dir[i]));
      assign readVal[i] = dir[i] ? latch[i] :
        (lcdSel[i] ? 1'b0 : pinSync[i]);
    end
  endgenerate
endmodule

// ### mfpg_top_assertions.sv
// concurrent checks on the port group top module ports
// assumes one clock domain, ce high while checks are meant to apply
`timescale 1ns/1ps
module mfpg_top_checker #(
  parameter int ADDR_W = 14,
  parameter int P5_W = 8
) (
  // clocking
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins and peripherals
  input wire logic [2:0] p2PadIn,
  input wire logic [2:0] p2PadOut,
  input wire logic [2:0] p2PadOeN,
  input wire logic [1:0] p3PadOeN,
  input wire logic [P5_W-1:0] p5PadOeN,
  input wire logic subOscEnable,
  input wire logic externalIrqFiveSet,
  input wire logic serialClockOutEnable
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);
  AST_ACK_NEXT:
  assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("request not acked next cycle");
  AST_RST_P2:
  assert property ($fell(srst) |-> p2PadOut == 3'h7)
    else $error("port 2 latch not ones after reset");
  AST_RST_P3:
  assert property ($fell(srst) |-> p3PadOeN == 2'h3 && !serialClockOutEnable)
    else $error("port 3 not released after reset");
  AST_RST_P5:
  assert property ($fell(srst) |-> &p5PadOeN)
    else $error("port 5 driving after reset");
  AST_IRQ:
  assert property ($fell(p2PadIn[0]) |-> ##[1:4] externalIrqFiveSet)
    else $error("no interrupt pulse after falling pin");
  AST_NO_FALSE_IRQ:
  assert property ($fell(srst) |-> (!externalIrqFiveSet) [*3])
    else $error("interrupt pulse right after reset");
  AST_IRQ_ONE:
  assert property (externalIrqFiveSet |=> !externalIrqFiveSet)
    else $error("interrupt pulse longer than one cycle");
  AST_OSC:
  assert property (subOscEnable |-> p2PadOeN[2:1] == 2'b11)
    else $error("oscillator pins driven in dual clock mode");
  AST_SCK:
  assert property (!$past(srst) && $changed(serialClockOutEnable) |->
    wb_ack_o && $past(wb_we_i && wb_adr_i == 14'h0010))
    else $error("serial clock enable changed without write");
  AST_P2_RD:
  assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 14'h0008)
    |-> wb_dat_o[31:3] == 29'h0)
    else $error("port 2 read has upper bits set");
  AST_P3_RD:
  assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 14'h000c)
    |-> (wb_dat_o & 32'hffffff67) == 32'h0)
    else $error("port 3 read has reserved bits set");
  cover property (externalIrqFiveSet);
  cover property (subOscEnable);
  cover property ($rose(serialClockOutEnable));
endmodule

bind mfpg_top mfpg_top_checker #(.ADDR_W(ADDR_W), .P5_W(P5_W)) u_chk (
  .clk(clk), .srst(srst), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .p2PadIn(p2PadIn),
  .p2PadOut(p2PadOut), .p2PadOeN(p2PadOeN), .p3PadOeN(p3PadOeN),
  .p5PadOeN(p5PadOeN), .subOscEnable(subOscEnable),
  .externalIrqFiveSet(externalIrqFiveSet),
  .serialClockOutEnable(serialClockOutEnable));

// ### mfpg_pin_model.sv
// external circuitry on a group of pins: pull-ups and optional drivers
// assumes the bench never drives a pin the block is driving
`timescale 1ns/1ps
module mfpg_pin_model #(
  parameter int W = 8
) (
  // block side
  input wire logic [W-1:0] padOut,
  input wire logic [W-1:0] padOeN,
  // far side drive
  input wire logic [W-1:0] extVal,
  input wire logic [W-1:0] extEn,
  // resolved level
  output logic [W-1:0] level
);
  // ----
  // resolution, pull-up when nobody drives
  // ----
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!padOeN[i]) level[i] = padOut[i];
      else if (extEn[i]) level[i] = extVal[i];
      else level[i] = 1'b1;
    end
  end
endmodule

// ### tb.sv
// self-checking bench for the port group behind classic wishbone
// assumes pin model for external circuitry, ce high except in the freeze test
`timescale 1ns/1ps
module tb import mfpg_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, divOut = 1'b0;
  logic [13:0] adr = 14'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic sck, sdo, osc, irq, p3DOut, p3DOeN;
  logic [7:0] seg = 8'h0, p5Out, p5OeN, p5Pin, p5Ev = 8'h0, p5Ee = 8'h0;
  logic [2:0] p2Out, p2OeN, p2Pin, p2Ev = 3'h0, p2Ee = 3'h0;
  logic [1:0] p3Out, p3OeN, p3Pin, p3Ev = 2'h0, p3Ee = 2'h0;
  int n_errors = 0, n_compared = 0;
  always #5 clk = ~clk;
  mfpg_top dut (.clk(clk), .srst(srst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .p2PadIn(p2Pin),
    .p2PadOut(p2Out), .p2PadOeN(p2OeN), .p3PadIn(p3Pin),
    .p3PadOut(p3Out), .p3PadOeN(p3OeN), .p3DivPadOut(p3DOut),
    .p3DivPadOeN(p3DOeN), .p5PadIn(p5Pin), .p5PadOut(p5Out),
    .p5PadOeN(p5OeN), .dividerOutput(divOut), .lcdSegment(seg),
    .subOscEnable(osc), .externalIrqFiveSet(irq),
    .serialClockOutEnable(sck), .serialDataOutEnable(sdo));
  mfpg_pin_model #(.W(3)) m2 (.padOut(p2Out), .padOeN(p2OeN),
    .extVal(p2Ev), .extEn(p2Ee), .level(p2Pin));
  mfpg_pin_model #(.W(2)) m3 (.padOut(p3Out), .padOeN(p3OeN),
    .extVal(p3Ev), .extEn(p3Ee), .level(p3Pin));
  mfpg_pin_model #(.W(8)) m5 (.padOut(p5Out), .padOeN(p5OeN),
    .extVal(p5Ev), .extEn(p5Ee), .level(p5Pin));
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [13:0] a,
                    input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [13:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h0, q);
    chk(q, {24'h0, e});
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rdc(14'h0008, 8'h07);
    rdc(14'h000c, 8'h98);
    rdc(14'h0010, 8'h00);
    rdc(14'h0028, 8'h00);
    rdc(14'h3e7c, 8'h00);
    chk(p5OeN, 8'hff);
    $display("reset test done");
  endtask
  task automatic t_port2();
    int n;
    n = 0;
    p2Ee <= 3'h2;
    wr(14'h0008, 8'h06);
    while (irq !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk(n < 10, 1'b1);
    rdc(14'h3e70, 8'h04);
    rdc(14'h0008, 8'h06);
    wr(14'h03c0, 8'h06);
    chk(p2OeN[0], 1'b1);
    wr(14'h03c0, 8'h01);
    chk(osc, 1'b1);
    wr(14'h0008, 8'h01);
    chk(p2OeN[2:1], 2'b11);
    wr(14'h03c0, 8'h00);
    chk(p2OeN[2:1], 2'b00);
    p2Ee <= 3'h0;
    wr(14'h0008, 8'h07);
    wr(14'h3e70, 8'h00);
    rdc(14'h3e70, 8'h07);
    $display("port 2 test done");
  endtask
  task automatic t_port3();
    wr(14'h000c, 8'h87);
    chk({p3OeN, p3Out, p3DOut}, 5'b00001);
    wr(14'h0010, 8'h18);
    wr(14'h000c, 8'h1f);
    chk({p3OeN, p3Out, p3DOut}, 5'b00110);
    repeat (2) @(posedge clk);
    rdc(14'h3e74, 8'h18);
    wr(14'h0010, 8'h06);
    chk({sck, sdo, p3OeN}, 4'b1111);
    rdc(14'h0010, 8'h06);
    wr(14'h000c, 8'h9f);
    p3Ee <= 2'h1;
    repeat (2) @(posedge clk);
    rdc(14'h3e74, 8'h10);
    p3Ee <= 2'h0;
    wr(14'h03c0, 8'h08);
    for (int i = 0; i < 2; i++) begin
      divOut <= i[0];
      @(posedge clk);
      chk(p3DOut, i[0]);
    end
    wr(14'h0010, 8'h00);
    wr(14'h03c0, 8'h00);
    $display("port 3 test done");
  endtask
  task automatic t_port5();
    seg <= 8'haa;
    p5Ev <= 8'h80;
    p5Ee <= 8'hc0;
    wr(14'h0014, 8'h55);
    wr(14'h0028, 8'h0f);
    wr(14'h3e7c, 8'h33);
    chk(p5OeN, 8'hc0);
    chk(p5Out, 8'h66);
    repeat (2) @(posedge clk);
    rdc(14'h0014, 8'h85);
    rdc(14'h0100, 8'h00);
    wr(14'h03c0, 8'h02);
    chk({p3DOeN, p5OeN}, 9'h1ff);
    wr(14'h03c0, 8'h00);
    chk({p3DOeN, p5OeN}, 9'h0c0);
    wr(14'h0028, 8'h00);
    wr(14'h3e7c, 8'h00);
    repeat (2) @(posedge clk);
    rdc(14'h0014, 8'hbf);
    $display("port 5 test done");
  endtask
  task automatic t_freeze();
    int n;
    n = 0;
    @(posedge clk);
    ce <= 1'b0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= 14'h0008;
    sel <= 4'h1;
    wdat <= 32'h0000_0005;
    repeat (3) @(posedge clk);
    chk({ack, p2Out}, 4'h7);
    ce <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(n < 20, 1'b1);
    rdc(14'h0008, 8'h05);
    $display("freeze test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_port2();
    t_port3();
    t_port5();
    t_freeze();
    summarize();
  end
endmodule
